// ### rtl/mcu_pin_function_mux.sv
// pin function mux: picks port bit or peripheral / external bus function per pin
// assumes: all peripheral signals come from logic on ref_clk; pins are asynchronous
// Notes on behaviour
// - port 0: low bus byte when external
// - port 1: high data byte on 16-bit bus
// - port 2: low address byte when external
// - port 3: mid address when enabled
// - port 4 low three: address 16-18
// - port 4 upper five: address 19-23
// - timer input enable feeds upper port 4
// - clock out pin when bus and enabled
// - ready sampled only when enabled on bus
// - hold acknowledge driven when hold enabled
// - hold request accepted only when hold enabled on bus; pin not driven
// - upper write strobe only on 16-bit bus
// - lower write strobe when bus and enabled
// - read strobe in every external mode
// - write inhibit input; port always usable
// - inhibit protects 512-byte ram region
// - ports 6 and 9 analog or open drain
// - port 7 carries compare outputs when enabled
// - port 8 low six: reload timer outputs
// - port 8 upper two: pulse generator outputs
// - port A 0-3 feed capture channels
// - port A 1-4 pulse width in or out
// - interrupt inputs accepted anytime when enabled
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_regs.svh"

module mcu_pin_function_mux #(
    parameter int NPORT = `PMX_NPORT,
    parameter int NPIN  = `PMX_NPIN
) (
    input  wire logic                      ref_clk,       // machine clock, 20 MHz
    input  wire logic                      rst,           // synchronous reset, high
    input  wire logic                      ce,            // clock enable, freezes all state
    input  wire logic [2:0]                mode_select_inputs, // strapped mode pins
    input  wire logic [`PMX_ADDR_W-1:0]    reg_addr,      // register word address
    input  wire logic [`PMX_DATA_W-1:0]    reg_wdata,     // register write data
    input  wire logic                      reg_wr,        // write strobe
    input  wire logic                      reg_rd,        // read strobe
    output logic      [`PMX_DATA_W-1:0]    reg_rdata,     // read data, cycle after strobe
    input  wire logic [NPIN-1:0]           pin_in,        // pin levels
    output logic      [NPIN-1:0]           pin_out,       // pin drive levels
    output logic      [NPIN-1:0]           pin_oe,        // pin drive enables
    output logic      [15:0]               analog_sel,    // pin routed to converter
    input  wire pin_mux_pkg::ext_bus_t     bus_req,       // bus controller pin values
    input  wire pin_mux_pkg::periph_out_t  periph_out,    // peripheral pin outputs
    output pin_mux_pkg::periph_in_t        periph_in,     // pin levels to peripherals
    input  wire logic                      ram_wr_en,     // core ram write request
    input  wire logic [`PMX_RAM_ADDR_W-1:0] ram_wr_addr,  // core ram write byte address
    output logic                           ram_wr_allow,  // ram write may proceed
    output logic                           ext_bus_on     // external bus mode active
);

    // ----------------------------------------
    // pin and mode synchronisers
    // ----------------------------------------
    logic [NPIN-1:0] pin_meta_r;
    logic [NPIN-1:0] pin_sync_r;
    logic [2:0]      mode_meta_r;
    logic [2:0]      mode_sync_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_meta_r  <= '0;
            pin_sync_r  <= '0;
            mode_meta_r <= `PMX_MODE_SINGLE;
            mode_sync_r <= `PMX_MODE_SINGLE;
        end else if (ce) begin
            pin_meta_r  <= pin_in;
            pin_sync_r  <= pin_meta_r;
            mode_meta_r <= mode_select_inputs;
            mode_sync_r <= mode_meta_r;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic [7:0]             pdata_r [NPORT];
    logic [7:0]             pdir_r  [NPORT];
    pin_mux_pkg::bus_ctl_t  busctl_r;
    logic [15:0]            anaen_r;
    logic [7:0]             cmpen_r;
    logic [7:0]             tmren_r;
    logic [7:0]             pwcctl_r;

    wire ext = (mode_sync_r != `PMX_MODE_SINGLE);

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire [`PMX_ADDR_W-1:0] pdata_idx = reg_addr - `PMX_PDATA_BASE;
    wire [`PMX_ADDR_W-1:0] pdir_idx  = reg_addr - `PMX_PDIR_BASE;
    wire [`PMX_ADDR_W-1:0] pin_idx   = reg_addr - `PMX_PIN_BASE;
    wire sel_pdata  = (reg_addr >= `PMX_PDATA_BASE) && (pdata_idx < NPORT[7:0]);
    wire sel_pdir   = (reg_addr >= `PMX_PDIR_BASE) && (pdir_idx < NPORT[7:0]);
    wire sel_pin    = (reg_addr >= `PMX_PIN_BASE) && (pin_idx < NPORT[7:0]);
    wire sel_busctl = (reg_addr == `PMX_BUSCTL);
    wire sel_anaen  = (reg_addr == `PMX_ANAEN);
    wire sel_cmpen  = (reg_addr == `PMX_CMPEN);
    wire sel_tmren  = (reg_addr == `PMX_TMREN);
    wire sel_pwcctl = (reg_addr == `PMX_PWCCTL);
    wire sel_status = (reg_addr == `PMX_STATUS);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busctl_r <= `PMX_BUSCTL_RST;
            anaen_r  <= `PMX_ANAEN_RST;
            cmpen_r  <= `PMX_CMPEN_RST;
            tmren_r  <= `PMX_TMREN_RST;
            pwcctl_r <= `PMX_PWCCTL_RST;
        end else if (ce && reg_wr) begin
            if (sel_busctl) begin
                busctl_r <= reg_wdata[11:0];
            end else if (sel_anaen) begin
                anaen_r <= reg_wdata;
            end else if (sel_cmpen) begin
                cmpen_r <= reg_wdata[7:0];
            end else if (sel_tmren) begin
                tmren_r <= reg_wdata[7:0];
            end else if (sel_pwcctl) begin
                pwcctl_r <= reg_wdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // port data and direction, one pair per port
    // ----------------------------------------
    logic [NPIN-1:0] pdata_flat;
    logic [NPIN-1:0] pdir_flat;
    logic [NPIN-1:0] pins_flat;

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                pdata_r[p] <= `PMX_PDATA_RST;
                pdir_r[p]  <= `PMX_PDIR_RST;
            end else if (ce && reg_wr) begin
                if (sel_pdata && pdata_idx == 8'(p)) begin
                    pdata_r[p] <= reg_wdata[7:0];
                end else if (sel_pdir && pdir_idx == 8'(p)) begin
                    pdir_r[p] <= reg_wdata[7:0];
                end
            end
        end
        assign pdata_flat[p*8 +: 8] = pdata_r[p];
        assign pdir_flat[p*8 +: 8]  = pdir_r[p];
    end
    assign pins_flat = pin_sync_r;

    // ----------------------------------------
    // read port
    // ----------------------------------------
    logic [`PMX_DATA_W-1:0] rdata_nxt;
    logic [`PMX_DATA_W-1:0] rdata_r;

    always_comb begin
        rdata_nxt = '0;
        if (sel_pdata) begin
            rdata_nxt = {8'h00, pdata_flat[pdata_idx[3:0]*8 +: 8]};
        end else if (sel_pdir) begin
            rdata_nxt = {8'h00, pdir_flat[pdir_idx[3:0]*8 +: 8]};
        end else if (sel_pin) begin
            rdata_nxt = {8'h00, pins_flat[pin_idx[3:0]*8 +: 8]};
        end else if (sel_busctl) begin
            rdata_nxt = {4'h0, busctl_r};
        end else if (sel_anaen) begin
            rdata_nxt = anaen_r;
        end else if (sel_cmpen) begin
            rdata_nxt = {8'h00, cmpen_r};
        end else if (sel_tmren) begin
            rdata_nxt = {8'h00, tmren_r};
        end else if (sel_pwcctl) begin
            rdata_nxt = {8'h00, pwcctl_r};
        end else if (sel_status) begin
            rdata_nxt = {12'h000, ext, mode_sync_r};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (ce) begin
            rdata_r <= reg_rd ? rdata_nxt : '0;
        end
    end
    assign reg_rdata = rdata_r;

    // ----------------------------------------
    // function ownership per pin
    // ----------------------------------------
    logic [NPIN-1:0] fn_own;
    logic [NPIN-1:0] fn_out;
    logic [NPIN-1:0] fn_oe;

    wire bus16 = ext && busctl_r.bus16;

    // port 0: low bus byte
    assign fn_own[7:0]   = {8{ext}};
    assign fn_out[7:0]   = bus_req.wdata[7:0];
    assign fn_oe[7:0]    = {8{bus_req.data_oe}};
    // port 1: high data byte
    assign fn_own[15:8]  = {8{bus16}};
    assign fn_out[15:8]  = bus_req.wdata[15:8];
    assign fn_oe[15:8]   = {8{bus_req.data_oe}};
    // port 2: low address byte
    assign fn_own[23:16] = {8{ext}};
    assign fn_out[23:16] = bus_req.addr[7:0];
    assign fn_oe[23:16]  = 8'hff;
    // port 3: mid address byte
    assign fn_own[31:24] = {8{ext && busctl_r.mid_addr_en}};
    assign fn_out[31:24] = bus_req.addr[15:8];
    assign fn_oe[31:24]  = 8'hff;
    // port 4: high and top address bits
    assign fn_own[34:32] = {3{ext && busctl_r.high_addr_en}};
    assign fn_own[39:35] = {5{ext && busctl_r.higher_addr_en}};
    assign fn_out[39:32] = bus_req.addr[23:16];
    assign fn_oe[39:32]  = 8'hff;
    // port 5: bus control pins
    assign fn_own[40] = ext && busctl_r.clk_en;
    assign fn_out[40] = bus_req.clk_level;
    assign fn_oe[40]  = 1'b1;
    assign fn_own[41] = ext && busctl_r.rdy_en;
    assign fn_out[41] = 1'b0;
    assign fn_oe[41]  = 1'b0;
    assign fn_own[42] = ext && busctl_r.hold_en;
    assign fn_out[42] = bus_req.hold_ack_out;
    assign fn_oe[42]  = 1'b1;
    assign fn_own[43] = ext && busctl_r.hold_en;
    assign fn_out[43] = 1'b0;
    assign fn_oe[43]  = 1'b0;
    assign fn_own[44] = bus16 && busctl_r.wrh_en;
    assign fn_out[44] = bus_req.write_strobe_upper;
    assign fn_oe[44]  = 1'b1;
    assign fn_own[45] = ext && busctl_r.wrl_en;
    assign fn_out[45] = bus_req.write_strobe_lower;
    assign fn_oe[45]  = 1'b1;
    assign fn_own[46] = ext;
    assign fn_out[46] = bus_req.rd_n;
    assign fn_oe[46]  = 1'b1;
    assign fn_own[47] = 1'b0;
    assign fn_out[47] = 1'b0;
    assign fn_oe[47]  = 1'b0;
    // ports 6 and 9: analog takes the pin off the port driver
    assign fn_own[55:48] = anaen_r[7:0];
    assign fn_own[79:72] = anaen_r[15:8];
    assign fn_out[55:48] = 8'h00;
    assign fn_out[79:72] = 8'h00;
    assign fn_oe[55:48]  = 8'h00;
    assign fn_oe[79:72]  = 8'h00;
    // port 7: compare outputs
    assign fn_own[63:56] = cmpen_r;
    assign fn_out[63:56] = periph_out.compare_outputs;
    assign fn_oe[63:56]  = 8'hff;
    // port 8: reload timer and pulse generator outputs
    assign fn_own[69:64] = tmren_r[5:0];
    assign fn_own[71:70] = tmren_r[7:6];
    assign fn_out[71:64] = {periph_out.pulse_gen_outputs, periph_out.reload_timer_outputs};
    assign fn_oe[71:64]  = 8'hff;
    // port A: pulse width outputs on bits 1-4, rest stay port
    assign fn_own[80]    = 1'b0;
    assign fn_own[84:81] = pwcctl_r[7:4];
    assign fn_own[87:85] = 3'b000;
    assign fn_out[80]    = 1'b0;
    assign fn_out[84:81] = periph_out.pulse_width_outputs;
    assign fn_out[87:85] = 3'b000;
    assign fn_oe[80]     = 1'b0;
    assign fn_oe[84:81]  = 4'hf;
    assign fn_oe[87:85]  = 3'b000;

    // ----------------------------------------
    // pin drive: function overrides port settings
    // ----------------------------------------
    logic [NPIN-1:0] out_nxt;
    logic [NPIN-1:0] oe_nxt;
    logic [NPIN-1:0] out_r;
    logic [NPIN-1:0] oe_r;

    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        localparam bit OPEN_DRAIN = (i >= 48 && i < 56) || (i >= 72 && i < 80);
        if (OPEN_DRAIN) begin : g_od
            // open drain: only ever pulls low
            assign out_nxt[i] = 1'b0;
            assign oe_nxt[i]  = fn_own[i] ? 1'b0 : (pdir_flat[i] && !pdata_flat[i]);
        end else begin : g_pp
            assign out_nxt[i] = fn_own[i] ? fn_out[i] : pdata_flat[i];
            assign oe_nxt[i]  = fn_own[i] ? fn_oe[i] : pdir_flat[i];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_r <= '0;
            oe_r  <= '0;
        end else if (ce) begin
            out_r <= out_nxt;
            oe_r  <= oe_nxt;
        end
    end
    assign pin_out = out_r;
    assign pin_oe  = oe_r;

    // ----------------------------------------
    // pin levels to peripherals
    // ----------------------------------------
    pin_mux_pkg::periph_in_t pin_fn_nxt;
    pin_mux_pkg::periph_in_t pin_fn_r;
    logic [15:0]             ana_r;
    logic                    ext_r;

    always_comb begin
        pin_fn_nxt = '0;
        pin_fn_nxt.bus_rdata = {bus16 ? pins_flat[15:8] : 8'h00, pins_flat[7:0]};
        pin_fn_nxt.ready = fn_own[41] ? pins_flat[41] : 1'b1;
        pin_fn_nxt.hold_req_in = fn_own[43] && pins_flat[43];
        pin_fn_nxt.ram_write_inhibit_in = pins_flat[47];
        pin_fn_nxt.reload_timer_inputs = busctl_r.tin_en ? pins_flat[39:35] : 5'h00;
        pin_fn_nxt.ext_irq_edge_inputs = busctl_r.irq_en ? pins_flat[39:35] : 5'h00;
        pin_fn_nxt.ext_irq_transfer_inputs = busctl_r.irq_en ? pins_flat[86:85] : 2'b00;
        pin_fn_nxt.capture_inputs = busctl_r.capture_en ? pins_flat[83:80] : 4'h0;
        pin_fn_nxt.pulse_width_inputs = pwcctl_r[3:0] & pins_flat[84:81];
    end

    // protected window check for ram writes
    wire [`PMX_RAM_ADDR_W-1:0] wi_off = ram_wr_addr - `PMX_WI_BASE;
    wire in_window = (ram_wr_addr >= `PMX_WI_BASE) && (wi_off < `PMX_WI_BYTES);
    wire allow_nxt = ram_wr_en && !(pins_flat[47] && in_window);

    logic allow_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_fn_r <= '0;
            ana_r    <= '0;
            ext_r    <= 1'b0;
            allow_r  <= 1'b0;
        end else if (ce) begin
            pin_fn_r <= pin_fn_nxt;
            ana_r    <= anaen_r;
            ext_r    <= ext;
            allow_r  <= allow_nxt;
        end
    end
    assign periph_in    = pin_fn_r;
    assign analog_sel   = ana_r;
    assign ext_bus_on   = ext_r;
    assign ram_wr_allow = allow_r;

endmodule

`default_nettype wire

// ### rtl/pin_mux_regs.svh
// register offsets, reset values, mode codes and sizes for the pin function mux
// assumes: included by bare name; word addressed register port with 8-bit address
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH

`define PMX_ADDR_W        8
`define PMX_DATA_W        16
`define PMX_NPORT         11
`define PMX_NPIN          88

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PMX_PDATA_BASE    8'h00
`define PMX_PDIR_BASE     8'h10
`define PMX_PIN_BASE      8'h20
`define PMX_BUSCTL        8'h30
`define PMX_ANAEN         8'h31
`define PMX_CMPEN         8'h32
`define PMX_TMREN         8'h33
`define PMX_PWCCTL        8'h34
`define PMX_STATUS        8'h35

// ----------------------------------------
// reset values
// ----------------------------------------
`define PMX_PDATA_RST     8'h00
`define PMX_PDIR_RST      8'h00
`define PMX_BUSCTL_RST    12'h000
`define PMX_ANAEN_RST     16'h0000
`define PMX_CMPEN_RST     8'h00
`define PMX_TMREN_RST     8'h00
`define PMX_PWCCTL_RST    8'h00

// ----------------------------------------
// mode code and protected ram window
// ----------------------------------------
`define PMX_MODE_SINGLE   3'h0
`define PMX_WI_BYTES      512
`define PMX_WI_BASE       16'h0100
`define PMX_RAM_ADDR_W    16

`endif

// ### rtl/pin_mux_pkg.sv
// types shared by the pin function mux and its surroundings
// assumes: nothing beyond a SystemVerilog compiler
package pin_mux_pkg;

    // bus and function control bits, bit 0 first from the bottom
    typedef struct packed {
        logic capture_en;
        logic irq_en;
        logic tin_en;
        logic higher_addr_en;
        logic high_addr_en;
        logic mid_addr_en;
        logic wrl_en;
        logic wrh_en;
        logic hold_en;
        logic rdy_en;
        logic clk_en;
        logic bus16;
    } bus_ctl_t;

    // what the bus controller wants on the pins
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic        data_oe;
        logic        rd_n;
        logic        write_strobe_upper;
        logic        write_strobe_lower;
        logic        hold_ack_out;
        logic        clk_level;
    } ext_bus_t;

    // peripheral outputs that may own pins
    typedef struct packed {
        logic [7:0] compare_outputs;
        logic [5:0] reload_timer_outputs;
        logic [1:0] pulse_gen_outputs;
        logic [3:0] pulse_width_outputs;
    } periph_out_t;

    // pin levels handed to the core and peripherals
    typedef struct packed {
        logic [15:0] bus_rdata;
        logic        ready;
        logic        hold_req_in;
        logic        ram_write_inhibit_in;
        logic [4:0]  reload_timer_inputs;
        logic [4:0]  ext_irq_edge_inputs;
        logic [1:0]  ext_irq_transfer_inputs;
        logic [3:0]  capture_inputs;
        logic [3:0]  pulse_width_inputs;
    } periph_in_t;

endpackage

// ### verif/pin_mux_chk.sv
// assertions on the pin function mux ports
// assumes: bound into the mux from the bench top; one clock domain, ce held high
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_regs.svh"

module pin_mux_chk #(
    parameter int NPIN = `PMX_NPIN
) (
    input wire logic                       ref_clk,      // clock
    input wire logic                       rst,          // sync reset
    input wire logic [`PMX_ADDR_W-1:0]     reg_addr,     // reg address
    input wire logic [`PMX_DATA_W-1:0]     reg_wdata,    // reg write data
    input wire logic                       reg_wr,       // reg write
    input wire logic [NPIN-1:0]            pin_out,      // pin level
    input wire logic [NPIN-1:0]            pin_oe,       // pin enable
    input wire pin_mux_pkg::ext_bus_t      bus_req,      // bus values
    input wire logic                       ram_wr_en,    // ram write
    input wire logic [`PMX_RAM_ADDR_W-1:0] ram_wr_addr,  // ram address
    input wire logic                       ram_wr_allow, // ram allowed
    input wire logic                       ext_bus_on    // bus mode
);
    // shadow of bus control, and what the mux flop saw one edge back
    pin_mux_pkg::bus_ctl_t ctl_r;
    pin_mux_pkg::bus_ctl_t c;
    pin_mux_pkg::ext_bus_t b;
    logic                  ext_r;
    logic                  on;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctl_r <= `PMX_BUSCTL_RST;
        end else if (reg_wr && reg_addr == `PMX_BUSCTL) begin
            ctl_r <= reg_wdata[11:0];
        end
        c     <= ctl_r;
        b     <= bus_req;
        ext_r <= ext_bus_on;
    end
    assign on = ext_bus_on && ext_r;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_port0; on |-> pin_out[7:0] == b.wdata[7:0] && pin_oe[7:0] == {8{b.data_oe}};
    endproperty
    a_port0: assert property (p_port0) else $error("port 0 not on bus");
    property p_port1; on && c.bus16 |-> pin_out[15:8] == b.wdata[15:8];
    endproperty
    a_port1: assert property (p_port1) else $error("port 1 not on bus");
    property p_port2; on |-> pin_out[23:16] == b.addr[7:0] && (&pin_oe[23:16]);
    endproperty
    a_port2: assert property (p_port2) else $error("port 2 not address");
    property p_port3; on && c.mid_addr_en |-> pin_out[31:24] == b.addr[15:8] && (&pin_oe[31:24]);
    endproperty
    a_port3: assert property (p_port3) else $error("port 3 not address");
    property p_addr_hi; on && c.high_addr_en |-> pin_out[34:32] == b.addr[18:16];
    endproperty
    a_addr_hi: assert property (p_addr_hi) else $error("port 4 low not address");
    property p_addr_top; on && c.higher_addr_en |-> pin_out[39:35] == b.addr[23:19];
    endproperty
    a_addr_top: assert property (p_addr_top) else $error("port 4 top not address");
    property p_clk; on && c.clk_en |-> pin_out[40] == b.clk_level && pin_oe[40];
    endproperty
    a_clk: assert property (p_clk) else $error("clock pin wrong");
    property p_hold; on && c.hold_en |-> pin_out[42] == b.hold_ack_out && pin_oe[42] ##0 !pin_oe[43];
    endproperty
    a_hold: assert property (p_hold) else $error("hold pins wrong");
    property p_ready; on && c.rdy_en |-> !pin_oe[41];
    endproperty
    a_ready: assert property (p_ready) else $error("ready pin driven");
    property p_wrh; on && c.bus16 && c.wrh_en |-> pin_out[44] == b.write_strobe_upper && pin_oe[44];
    endproperty
    a_wrh: assert property (p_wrh) else $error("upper strobe wrong");
    property p_wrl; on && c.wrl_en |-> pin_out[45] == b.write_strobe_lower && pin_oe[45];
    endproperty
    a_wrl: assert property (p_wrl) else $error("lower strobe wrong");
    property p_rd; on |-> pin_out[46] == b.rd_n && pin_oe[46];
    endproperty
    a_rd: assert property (p_rd) else $error("read strobe wrong");
    property p_ram; !($past(ram_wr_addr) inside {[16'h0100:16'h02ff]}) |->
        ram_wr_allow == $past(ram_wr_en);
    endproperty
    a_ram: assert property (p_ram) else $error("ram write blocked outside window");
endmodule
`default_nettype wire

// ### verif/pin_far_model.sv
// far side of the pins: external memory on the bus plus board drivers
// assumes: pin index is port*8+bit; open-drain ports 6 and 9 have pull-ups
`timescale 1ns/1ps
`default_nettype none

module pin_far_model (
    input  wire logic [87:0] pin_out, // device drive level
    input  wire logic [87:0] pin_oe,  // device drive enable
    input  wire logic [87:0] far_val, // board drive levels
    output logic      [87:0] pin_in   // resolved pin level
);
    // memory answers {~a, a} while the read strobe is low
    logic        rd_act;
    logic [87:0] drv;

    assign rd_act = pin_oe[46] && !pin_out[46];

    always_comb begin
        drv = far_val;
        if (rd_act) begin
            drv[15:0] = {~pin_out[23:16], pin_out[23:16]};
        end
        drv[55:48] = 8'hff;
        drv[79:72] = 8'hff;
        for (int i = 0; i < 88; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : drv[i];
        end
    end
endmodule
`default_nettype wire

// ### verif/mcu_pin_function_mux_tb_top.sv
// self-checking bench for the pin function mux and its far side model
// assumes: package, header, design, far side model and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_regs.svh"

module mcu_pin_function_mux_tb_top;
    logic                     ref_clk, rst, reg_wr, reg_rd, ram_wr_en, ram_wr_allow, ext_bus_on;
    logic [2:0]               mode_select_inputs;
    logic [7:0]               reg_addr;
    logic [15:0]              reg_wdata, reg_rdata, analog_sel, ram_wr_addr;
    logic [87:0]              pin_in, pin_out, pin_oe, far_val;
    pin_mux_pkg::ext_bus_t    bus_req;
    pin_mux_pkg::periph_out_t periph_out;
    pin_mux_pkg::periph_in_t  periph_in;
    int                       failures = 0;
    int                       checked  = 0;
    int                       cycles   = 0;

    mcu_pin_function_mux i_mcu_pin_function_mux (
        .ref_clk, .rst, .ce(1'b1), .mode_select_inputs, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe, .analog_sel, .bus_req, .periph_out,
        .periph_in, .ram_wr_en, .ram_wr_addr, .ram_wr_allow, .ext_bus_on);
    pin_far_model i_pin_far_model (.pin_out, .pin_oe, .far_val, .pin_in);

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            final_report();
        end
    end

    task automatic final_report;
        if (failures == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [87:0] seen, input logic [87:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    // pin sync and mux flops are three edges deep at most
    task automatic settle;
        repeat (6) @(posedge ref_clk);
        #1;
    endtask

    function automatic logic [7:0] pd(input int p);
        return 8'h5a ^ 8'(p);
    endfunction

    task automatic t_single;
        chk(pin_oe, 88'h0);
        rd(`PMX_BUSCTL, 16'h0000);
        rd(`PMX_STATUS, 16'h0000);
        rd(8'h40, 16'h0000);
        for (int p = 0; p < 6; p++) begin
            wr(8'(p), {8'h00, pd(p)});
            wr(8'h10 + 8'(p), 16'h00ff);
        end
        wr(`PMX_BUSCTL, 16'h0fff);
        settle();
        chk(pin_out[47:0], {pd(5), pd(4), pd(3), pd(2), pd(1), pd(0)});
        chk(pin_oe[47:0], 48'hffff_ffff_ffff);
    endtask

    task automatic t_ext;
        @(posedge ref_clk);
        mode_select_inputs <= 3'h1;
        // addr, wdata, then oe, rd, upper, lower, hold ack, clock
        bus_req <= {24'hab_cdef, 16'h1034, 6'h3b};
        settle();
        rd(`PMX_STATUS, 16'h0009);
        chk(ext_bus_on, 1'b1);
        chk(pin_out[39:0], 40'hab_cdef_1034);
        chk({pin_out[46:44], pin_out[42], pin_out[40], pin_oe[46:40]}, 12'hbf5);
        @(posedge ref_clk);
        {bus_req.data_oe, bus_req.rd_n} <= 2'b00;
        settle();
        chk(periph_in.bus_rdata, 16'h10ef);
        wr(`PMX_BUSCTL, 16'h0ffe);
        settle();
        chk(periph_in.bus_rdata, 16'h00ef);
        chk({pin_out[44], pin_out[15:8]}, 9'h15b);
        wr(`PMX_BUSCTL, 16'h0000);
        settle();
        chk(pin_out[46:16], {1'b0, 6'h1f, pd(4), pd(3), 8'hef});
    endtask

    task automatic t_inputs;
        wr(`PMX_BUSCTL, 16'h0fff);
        wr(`PMX_PWCCTL, 16'h000f);
        far_val <= {8'h6b, 80'h0000_0000_0800_0000_0000};
        settle();
        chk(periph_in.reload_timer_inputs, 5'h15);
        chk(periph_in.ext_irq_edge_inputs, 5'h15);
        chk(periph_in.ext_irq_transfer_inputs, 2'h3);
        chk(periph_in.capture_inputs, 4'hb);
        chk(periph_in.pulse_width_inputs, 4'h5);
        chk({periph_in.ready, periph_in.hold_req_in}, 2'h1);
        rd(8'h2a, 16'h006b);
        wr(`PMX_BUSCTL, 16'h0dfb);
        settle();
        chk({periph_in.ready, periph_in.reload_timer_inputs}, 6'h20);
    endtask

    task automatic t_periph;
        wr(`PMX_CMPEN, 16'h00ff);
        wr(`PMX_TMREN, 16'h00ff);
        wr(`PMX_PWCCTL, 16'h00f0);
        wr(8'h16, 16'h00ff);
        wr(8'h19, 16'h00ff);
        wr(`PMX_ANAEN, 16'h00ff);
        periph_out <= {8'hc3, 6'h2d, 2'h2, 4'h9};
        settle();
        chk(pin_out[71:56], {2'h2, 6'h2d, 8'hc3});
        chk(pin_oe[71:56], 16'hffff);
        chk({pin_out[84:81], pin_oe[84:81]}, 8'h9f);
        chk({analog_sel, pin_oe[79:72], pin_oe[55:48]}, 32'h00ff_ff00);
        wr(`PMX_CMPEN, 16'h0000);
        wr(`PMX_TMREN, 16'h0000);
        wr(`PMX_PWCCTL, 16'h0000);
        settle();
        chk({pin_oe[84:81], pin_oe[71:56]}, 20'h0);
    endtask

    task automatic t_inhibit;
        logic [15:0] addrs [5] = '{16'h0100, 16'h02ff, 16'h0300, 16'h00ff, 16'h0100};
        logic [4:0]  allow = 5'h1c;
        wr(8'h05, 16'h00df);
        settle();
        chk(periph_in.ram_write_inhibit_in, 1'b1);
        for (int i = 0; i < 5; i++) begin
            if (i == 4) begin
                wr(8'h05, 16'h005f);
                settle();
            end
            @(posedge ref_clk);
            {ram_wr_addr, ram_wr_en} <= {addrs[i], 1'b1};
            repeat (2) @(posedge ref_clk);
            #1 chk(ram_wr_allow, allow[i]);
        end
        ram_wr_en <= 1'b0;
    endtask

    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, ram_wr_en} = 3'h0;
        {mode_select_inputs, reg_addr, reg_wdata, ram_wr_addr} = '0;
        {bus_req, periph_out, far_val} = '0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        t_single();
        t_ext();
        t_inputs();
        t_periph();
        t_inhibit();
        final_report();
    end
endmodule

bind mcu_pin_function_mux pin_mux_chk #(.NPIN(NPIN)) i_pin_mux_chk (
    .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .pin_out, .pin_oe, .bus_req,
    .ram_wr_en, .ram_wr_addr, .ram_wr_allow, .ext_bus_on);
`default_nettype wire
